/* File: verilog/msm_pkg.sv */
// package of constants and types, plus the pipelined signed multiplier
// Contract
// RULE_01: peripheral move opmode 100..111 = word/long load, word/long store.
// RULE_02: peripheral move address is address register plus sign-extended 16-bit displacement.
// RULE_03: peripheral move steps by two, most significant byte first.
// RULE_04: quick move sign-extends the low opcode byte into all 32 data bits.
// RULE_05: quick move sets N and Z, clears V and C, keeps X.
// RULE_06: alternate-space move runs only in supervisor state, else privilege trap.
// RULE_07: alternate-space store uses destination code, load uses source code.
// RULE_08: alternate-space load merges low bits of data register, sign-extends address register.
// RULE_09: alternate-space size codes 00 byte, 01 word, 10 long.
// RULE_10: extension type bit 0 data 1 address; direction 0 load, 1 store.
// RULE_11: alternate-space move accepts only memory alterable address modes.
// RULE_12: storing the base register with postinc or predec stores the updated address.
// RULE_13: word multiply uses low 16 bits of both operands, full 32-bit product.
// RULE_14: long multiply gives 64-bit product, low half only or split over two registers.
// RULE_15: multiply sets N and Z, clears C, V only on 32-bit long overflow.
// RULE_16: multiply writes V from overflow each time, never touches X.
// RULE_17: word multiply opcode holds destination above opmode, opmode all ones.
// RULE_18: multiply source takes every data mode except address register direct.
// RULE_19: long multiply size bit 1 selects 64 bits; same high and low is undefined.
// RULE_20: disallowed encodings raise illegal instruction and change nothing.
package msm_pkg;
  // apb register word offsets
  localparam logic [7:0] OFS_OPWORD = 8'h00;
  localparam logic [7:0] OFS_EXTWORD = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_FCODE = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_CCR = 8'h14;
  localparam logic [7:0] OFS_EAADDR = 8'h18;
  localparam logic [7:0] OFS_IMM = 8'h1C;
  localparam logic [7:0] OFS_DREG = 8'h20;
  localparam logic [7:0] OFS_AREG = 8'h40;
  localparam logic [7:0] OFS_END = 8'h60;
  // control and status bit positions
  localparam int CTRL_GO = 0;
  localparam int CTRL_SUPER = 1;
  localparam int FC_SRC_LSB = 0;
  localparam int FC_DST_LSB = 4;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_ILLEGAL = 2;
  localparam int ST_PRIV = 3;
  // condition code positions
  localparam int CC_X = 4;
  localparam int CC_N = 3;
  localparam int CC_Z = 2;
  localparam int CC_V = 1;
  localparam int CC_C = 0;
  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [4:0] RST_CCR = 5'h00;
  localparam logic [2:0] RST_FC = 3'h0;
  // opcode patterns
  localparam logic [3:0] LINE_ZERO = 4'h0;
  localparam logic [3:0] LINE_QUICK = 4'h7;
  localparam logic [3:0] LINE_MULW = 4'hC;
  localparam logic [7:0] PAT_ALTSPACE = 8'h0E;
  localparam logic [9:0] PAT_MULL = 10'h130;
  localparam logic [2:0] OPM_MULW = 3'b111;
  localparam logic [2:0] MODE_PMOVE = 3'b001;
  // effective address modes
  localparam logic [2:0] EA_DREG = 3'b000;
  localparam logic [2:0] EA_AREG = 3'b001;
  localparam logic [2:0] EA_IND = 3'b010;
  localparam logic [2:0] EA_POSTINC = 3'b011;
  localparam logic [2:0] EA_PREDEC = 3'b100;
  localparam logic [2:0] EA_INDEX = 3'b110;
  localparam logic [2:0] EA_EXT = 3'b111;
  localparam logic [2:0] EXT_ABSL = 3'b001;
  localparam logic [2:0] EXT_IMM = 3'b100;
  // operand sizes
  localparam logic [1:0] SZ_BYTE = 2'b00;
  localparam logic [1:0] SZ_WORD = 2'b01;
  localparam logic [1:0] SZ_LONG = 2'b10;
  localparam logic [2:0] PMOVE_STEP = 3'd2;
  localparam int MUL_LATENCY = 2;

  typedef enum logic [2:0] {K_PMOVE, K_QUICK, K_MOVES, K_MULW, K_MULL} msm_kind_t;
  typedef enum logic [2:0] {S_IDLE, S_DEC, S_MEM, S_MUL, S_WB} msm_state_t;
endpackage

`timescale 1ns/10ps
// two-stage signed 32x32 multiplier, done two edges after start
module msm_mul (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [31:0] op_a,
  input wire logic [31:0] op_b,
  output logic done,
  output logic [63:0] prod
);
  import msm_pkg::*;
  logic [31:0] a_r;
  logic [31:0] b_r;
  logic [1:0] stage_r;

  // operand capture stage keeps the product path off the regfile mux
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      a_r <= RST_WORD;
      b_r <= RST_WORD;
      stage_r <= 2'b00;
      prod <= {RST_WORD, RST_WORD};
    end
    else
    begin
      stage_r <= {stage_r[0], start};
      if (start)
      begin
        a_r <= op_a;
        b_r <= op_b;
      end
      if (stage_r[0])
        prod <= $signed(a_r) * $signed(b_r);  // see RULE_14
    end
  end

  assign done = stage_r[1];
endmodule

/* File: verilog/msm_exec.sv */
// decode and execute unit for peripheral, quick, alternate-space moves and signed multiply
`timescale 1ns/10ps
module msm_exec (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [1:0] mem_size,
  output logic [2:0] mem_fc,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output logic illegal_evt,
  output logic priv_evt
);
  import msm_pkg::*;

  msm_state_t state_r;
  msm_kind_t kind_r;
  logic [15:0] opword_r;
  logic [15:0] ext_r;
  logic super_r;
  logic [2:0] sfc_r;
  logic [2:0] dfc_r;
  logic [4:0] ccr_r;
  logic [31:0] eaaddr_r;
  logic [31:0] imm_r;
  logic [31:0] d_r [0:7];
  logic [31:0] a_r [0:7];
  logic done_r;
  logic illegal_r;
  logic priv_r;
  logic [31:0] maddr_r;
  logic [1:0] msize_r;
  logic mwe_r;
  logic [2:0] mfc_r;
  logic [31:0] xfer_r;
  logic [2:0] bytes_r;
  logic mul_wait_r;
  logic [63:0] prod;
  logic mul_done;

  // apb decode; zero wait states
  logic wr_en;
  logic rd_sel;
  logic [7:0] ofs;
  logic idle;
  logic go;
  logic map_ok;
  assign ofs = paddr[7:0];
  assign idle = (state_r == S_IDLE);
  assign wr_en = psel && penable && pwrite;
  assign rd_sel = psel && !pwrite;
  assign map_ok = (paddr[31:8] == 24'h00_0000) && (paddr[1:0] == 2'b00) && (ofs < OFS_END);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !map_ok;
  assign go = wr_en && map_ok && idle && (ofs == OFS_CTRL) && pwdata[CTRL_GO];

  // opcode fields
  logic [2:0] f_dreg;
  logic [2:0] f_mode;
  logic [2:0] f_reg;
  logic [2:0] f_xreg;
  assign f_dreg = opword_r[11:9];
  assign f_mode = opword_r[5:3];
  assign f_reg = opword_r[2:0];
  assign f_xreg = ext_r[14:12];

  // instruction recognition
  logic is_pmove;
  logic is_quick;
  logic is_moves;
  logic is_mulw;
  logic is_mull;
  logic mem_alt;
  logic data_ok;
  assign is_pmove = (opword_r[15:12] == LINE_ZERO) && opword_r[8] &&
                    (f_mode == MODE_PMOVE);  // see RULE_01
  assign is_quick = (opword_r[15:12] == LINE_QUICK) && !opword_r[8];
  assign is_moves = (opword_r[15:8] == PAT_ALTSPACE) && (opword_r[7:6] != 2'b11) &&
                    (ext_r[10:0] == 11'h000);  // see RULE_09
  assign is_mulw = (opword_r[15:12] == LINE_MULW) && (opword_r[8:6] == OPM_MULW);  // see RULE_17
  assign is_mull = (opword_r[15:6] == PAT_MULL) && !ext_r[15] && ext_r[11] &&
                   (ext_r[9:3] == 7'h00);
  // memory alterable: no register direct, immediate or pc relative
  assign mem_alt = ((f_mode >= EA_IND) && (f_mode <= EA_INDEX)) ||
                   ((f_mode == EA_EXT) && (f_reg <= EXT_ABSL));  // see RULE_11
  // data modes: everything but address register direct
  assign data_ok = (f_mode != EA_AREG) && ((f_mode != EA_EXT) || (f_reg <= EXT_IMM));  // see RULE_18

  // operand size in bytes for the ea forms
  logic [1:0] ea_size;
  logic [31:0] sz_bytes;
  logic [31:0] base;
  logic [31:0] an_new;
  logic [31:0] ea;
  logic an_upd;
  always_comb
  begin
    ea_size = is_moves ? opword_r[7:6] : (is_mulw ? SZ_WORD : SZ_LONG);
    unique case (ea_size)
      SZ_BYTE: sz_bytes = 32'h0000_0001;
      SZ_WORD: sz_bytes = 32'h0000_0002;
      default: sz_bytes = 32'h0000_0004;
    endcase
    base = a_r[f_reg];
    an_upd = (f_mode == EA_POSTINC) || (f_mode == EA_PREDEC);
    an_new = (f_mode == EA_PREDEC) ? base - sz_bytes : base + sz_bytes;
    if (f_mode == EA_IND || f_mode == EA_POSTINC)
      ea = base;
    else if (f_mode == EA_PREDEC)
      ea = an_new;
    else
      ea = eaaddr_r;
  end

  // store data for the alternate-space move picks up an updated base
  logic [31:0] st_val;
  always_comb
  begin
    st_val = ext_r[15] ? a_r[f_xreg] : d_r[f_xreg];  // see RULE_10
    if (ext_r[15] && (f_xreg == f_reg) && an_upd)
      st_val = an_new;  // see RULE_12
  end

  // decode outcome taken in S_DEC
  logic dec_illegal;
  logic dec_priv;
  logic dec_mem;
  assign dec_illegal = !(is_pmove || is_quick || (is_moves && mem_alt) ||
                         ((is_mulw || is_mull) && data_ok));  // see RULE_20
  assign dec_priv = is_moves && !super_r;  // see RULE_06
  assign dec_mem = is_moves || ((is_mulw || is_mull) && (f_mode != EA_DREG) &&
                   !((f_mode == EA_EXT) && (f_reg == EXT_IMM)));
  logic dec_upd;
  assign dec_upd = (state_r == S_DEC) && !dec_illegal && !dec_priv && !is_pmove &&
                   !is_quick && an_upd;

  // sequencer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= S_IDLE;
      kind_r <= K_QUICK;
      maddr_r <= RST_WORD;
      msize_r <= SZ_BYTE;
      mwe_r <= 1'b0;
      mfc_r <= RST_FC;
      xfer_r <= RST_WORD;
      bytes_r <= 3'd0;
      mul_wait_r <= 1'b0;
    end
    else
    begin
      unique case (state_r)
        S_IDLE:
          if (go)
            state_r <= S_DEC;
        S_DEC:
        begin
          if (dec_illegal || dec_priv)
            state_r <= S_IDLE;
          else if (is_pmove)
          begin
            kind_r <= K_PMOVE;
            maddr_r <= base + {{16{ext_r[15]}}, ext_r};  // see RULE_02
            msize_r <= SZ_BYTE;
            mwe_r <= opword_r[7];
            mfc_r <= super_r ? 3'd5 : 3'd1;
            bytes_r <= opword_r[6] ? 3'd4 : 3'd2;
            // most significant byte is parked in the top lane
            xfer_r <= opword_r[6] ? d_r[f_dreg] : {d_r[f_dreg][15:0], 16'h0000};  // see RULE_03
            state_r <= S_MEM;
          end
          else if (is_quick)
          begin
            kind_r <= K_QUICK;
            state_r <= S_WB;
          end
          else
          begin
            kind_r <= is_moves ? K_MOVES : (is_mulw ? K_MULW : K_MULL);
            maddr_r <= ea;
            msize_r <= ea_size;
            mwe_r <= is_moves && ext_r[11];
            mfc_r <= (is_moves && ext_r[11]) ? dfc_r : (is_moves ? sfc_r : 3'd5);  // see RULE_07
            bytes_r <= 3'd1;
            xfer_r <= (f_mode == EA_DREG) ? d_r[f_reg] : (is_moves ? st_val : imm_r);
            state_r <= dec_mem ? S_MEM : S_MUL;
          end
        end
        S_MEM:
          if (mem_ack)
          begin
            bytes_r <= bytes_r - 3'd1;
            if (kind_r == K_PMOVE)
            begin
              maddr_r <= maddr_r + {29'h0000_0000, PMOVE_STEP};  // see RULE_03
              xfer_r <= {xfer_r[23:0], mwe_r ? 8'h00 : mem_rdata[7:0]};
            end
            else if (!mwe_r)
              xfer_r <= mem_rdata;
            if (bytes_r == 3'd1)
              state_r <= (kind_r == K_MULW || kind_r == K_MULL) ? S_MUL : S_WB;
          end
        S_MUL:
        begin
          mul_wait_r <= 1'b1;
          if (mul_done)
          begin
            mul_wait_r <= 1'b0;
            state_r <= S_WB;
          end
        end
        S_WB:
          state_r <= S_IDLE;
      endcase
    end
  end

  // memory port; byte lane sits low during peripheral moves
  assign mem_req = (state_r == S_MEM);
  assign mem_we = mwe_r;
  assign mem_addr = maddr_r;
  assign mem_size = msize_r;
  assign mem_fc = mfc_r;
  assign mem_wdata = (kind_r == K_PMOVE) ? {24'h00_0000, xfer_r[31:24]} : xfer_r;

  // multiplier operands
  logic [31:0] mul_a;
  logic [31:0] mul_b;
  assign mul_a = (kind_r == K_MULW) ? {{16{d_r[f_dreg][15]}}, d_r[f_dreg][15:0]} :
                 d_r[f_xreg];  // see RULE_13
  assign mul_b = (kind_r == K_MULW) ? {{16{xfer_r[15]}}, xfer_r[15:0]} : xfer_r;

  msm_mul u_mul (
    .pclk(pclk),
    .presetn(presetn),
    .start((state_r == S_MUL) && !mul_wait_r),
    .op_a(mul_a),
    .op_b(mul_b),
    .done(mul_done),
    .prod(prod)
  );

  // writeback selection: two data ports, one address port, flags
  logic wb0_en;
  logic [2:0] wb0_idx;
  logic [31:0] wb0_val;
  logic wb1_en;
  logic [2:0] wb1_idx;
  logic wb_a_en;
  logic [31:0] wb_a_val;
  logic cc_en;
  logic [4:0] cc_val;
  logic [31:0] ld_sext;
  logic [31:0] ld_merge;
  logic [31:0] q_val;
  always_comb
  begin
    wb0_en = 1'b0;
    wb0_idx = f_dreg;
    wb0_val = prod[31:0];
    wb1_en = 1'b0;
    wb1_idx = ext_r[2:0];
    wb_a_en = 1'b0;
    cc_en = 1'b0;
    cc_val = ccr_r;
    q_val = {{24{opword_r[7]}}, opword_r[7:0]};  // see RULE_04
    unique case (msize_r)
      SZ_BYTE: ld_sext = {{24{xfer_r[7]}}, xfer_r[7:0]};
      SZ_WORD: ld_sext = {{16{xfer_r[15]}}, xfer_r[15:0]};
      default: ld_sext = xfer_r;
    endcase
    unique case (msize_r)
      SZ_BYTE: ld_merge = {d_r[f_xreg][31:8], xfer_r[7:0]};
      SZ_WORD: ld_merge = {d_r[f_xreg][31:16], xfer_r[15:0]};
      default: ld_merge = xfer_r;
    endcase
    wb_a_val = ld_sext;
    if (state_r == S_WB)
    begin
      unique case (kind_r)
        K_QUICK:
        begin
          wb0_en = 1'b1;
          wb0_val = q_val;
          cc_en = 1'b1;
          cc_val = {ccr_r[CC_X], q_val[31], q_val == 32'h0000_0000, 2'b00};  // see RULE_05
        end
        K_PMOVE:
        begin
          wb0_en = !mwe_r;
          wb0_val = opword_r[6] ? xfer_r : {d_r[f_dreg][31:16], xfer_r[15:0]};  // see RULE_01
        end
        K_MOVES:
        begin
          wb0_en = !mwe_r && !ext_r[15];
          wb0_idx = f_xreg;
          wb0_val = ld_merge;  // see RULE_08
          wb_a_en = !mwe_r && ext_r[15];  // see RULE_08
        end
        K_MULW:
        begin
          wb0_en = 1'b1;
          cc_en = 1'b1;
          cc_val = {ccr_r[CC_X], prod[31], prod[31:0] == 32'h0000_0000, 2'b00};  // see RULE_15
        end
        K_MULL:
        begin
          wb0_en = 1'b1;
          wb0_idx = f_xreg;
          wb1_en = ext_r[10];  // see RULE_19
          cc_en = 1'b1;
          if (ext_r[10])
            cc_val = {ccr_r[CC_X], prod[63], prod == 64'h0000_0000_0000_0000, 2'b00};
          else
            cc_val = {ccr_r[CC_X], prod[31], prod[31:0] == 32'h0000_0000,
                      prod[63:32] != {32{prod[31]}}, 1'b0};  // see RULE_16
        end
        default:
          cc_en = 1'b0;
      endcase
    end
  end

  // register file; software writes only while idle, high product written last
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 8; i++)
      begin
        d_r[i] <= RST_WORD;
        a_r[i] <= RST_WORD;
      end
    end
    else
    begin
      for (int i = 0; i < 8; i++)
      begin
        if (wr_en && map_ok && idle && (ofs == OFS_DREG + 8'(4 * i)))
          d_r[i] <= pwdata;
        if (wr_en && map_ok && idle && (ofs == OFS_AREG + 8'(4 * i)))
          a_r[i] <= pwdata;
      end
      if (dec_upd)
        a_r[f_reg] <= an_new;  // see RULE_12
      if (wb0_en)
        d_r[wb0_idx] <= wb0_val;
      if (wb1_en)
        d_r[wb1_idx] <= prod[63:32];  // see RULE_14
      if (wb_a_en)
        a_r[f_xreg] <= wb_a_val;
    end
  end

  // software control registers and flags
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      opword_r <= 16'h0000;
      ext_r <= 16'h0000;
      super_r <= 1'b0;
      sfc_r <= RST_FC;
      dfc_r <= RST_FC;
      ccr_r <= RST_CCR;
      eaaddr_r <= RST_WORD;
      imm_r <= RST_WORD;
    end
    else
    begin
      if (wr_en && map_ok && idle)
      begin
        unique case (ofs)
          OFS_OPWORD: opword_r <= pwdata[15:0];
          OFS_EXTWORD: ext_r <= pwdata[15:0];
          OFS_CTRL: super_r <= pwdata[CTRL_SUPER];
          OFS_FCODE:
          begin
            sfc_r <= pwdata[FC_SRC_LSB +: 3];
            dfc_r <= pwdata[FC_DST_LSB +: 3];
          end
          OFS_CCR: ccr_r <= pwdata[4:0];
          OFS_EAADDR: eaaddr_r <= pwdata;
          OFS_IMM: imm_r <= pwdata;
          default: ccr_r <= ccr_r;
        endcase
      end
      if (cc_en)
        ccr_r <= cc_val;
    end
  end

  // sticky status, write one to clear; a new event beats the clear
  logic set_done;
  logic set_ill;
  logic set_priv;
  logic [3:0] st_clr;
  assign set_done = (state_r == S_WB);
  assign set_ill = (state_r == S_DEC) && dec_illegal;  // see RULE_20
  assign set_priv = (state_r == S_DEC) && !dec_illegal && dec_priv;  // see RULE_06
  assign st_clr = (wr_en && map_ok && (ofs == OFS_STATUS)) ? pwdata[3:0] : 4'h0;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      done_r <= 1'b0;
      illegal_r <= 1'b0;
      priv_r <= 1'b0;
      illegal_evt <= 1'b0;
      priv_evt <= 1'b0;
    end
    else
    begin
      done_r <= set_done || (done_r && !st_clr[ST_DONE]);
      illegal_r <= set_ill || (illegal_r && !st_clr[ST_ILLEGAL]);
      priv_r <= set_priv || (priv_r && !st_clr[ST_PRIV]);
      illegal_evt <= set_ill;
      priv_evt <= set_priv;
    end
  end

  // read mux; unmapped reads return zero
  always_comb
  begin
    prdata = RST_WORD;
    if (rd_sel && map_ok)
    begin
      if (ofs >= OFS_AREG)
        prdata = a_r[ofs[4:2]];
      else if (ofs >= OFS_DREG)
        prdata = d_r[ofs[4:2]];
      else
      begin
        unique case (ofs)
          OFS_OPWORD: prdata = {16'h0000, opword_r};
          OFS_EXTWORD: prdata = {16'h0000, ext_r};
          OFS_CTRL: prdata = {30'h0000_0000, super_r, 1'b0};
          OFS_FCODE: prdata = {25'h000_0000, dfc_r, 1'b0, sfc_r};
          OFS_STATUS: prdata = {28'h000_0000, priv_r, illegal_r, done_r, !idle};
          OFS_CCR: prdata = {27'h000_0000, ccr_r};
          OFS_EAADDR: prdata = eaaddr_r;
          default: prdata = imm_r;
        endcase
      end
    end
  end
endmodule

/* File: verif/msm_mem_model.sv */
// byte-wide memory model answering the exec unit's bus requests
`timescale 1ns/10ps
module msm_mem_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [1:0] mem_size,
  input wire logic [2:0] mem_fc,
  input wire logic [31:0] mem_wdata,
  input wire logic [3:0] dly,
  output logic mem_ack,
  output logic [31:0] mem_rdata,
  output logic [2:0] seen_fc
);
  logic [7:0] mem [0:255];
  logic [3:0] cnt_r;
  logic [31:0] rd;
  logic [7:0] a;
  int n;
  assign a = mem_addr[7:0];
  assign n = (mem_size == 2'b00) ? 1 : (mem_size == 2'b01) ? 2 : 4;
  // big-endian assembly, narrow data right-aligned
  always_comb
  begin
    case (mem_size)
      2'b00: rd = {24'h00_0000, mem[a]};
      2'b01: rd = {16'h0000, mem[a], mem[a + 8'd1]};
      default: rd = {mem[a], mem[a + 8'd1], mem[a + 8'd2], mem[a + 8'd3]};
    endcase
  end
  // inverted outside ack so a stale value never passes for data
  assign mem_rdata = mem_ack ? rd : ~rd;
  // one-cycle ack after dly waiting cycles
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mem_ack <= 1'b0;
      cnt_r <= 4'h0;
    end
    else if (mem_ack)
    begin
      mem_ack <= 1'b0;
      cnt_r <= 4'h0;
    end
    else if (mem_req && cnt_r >= dly)
      mem_ack <= 1'b1;
    else if (mem_req)
      cnt_r <= cnt_r + 4'h1;
  end
  // writes land at the accepting edge, msb at the lowest address
  always @(posedge pclk)
  begin
    if (mem_req && mem_ack)
    begin
      seen_fc <= mem_fc;
      for (int i = 0; i < n; i++)
        if (mem_we)
          mem[a + 8'(i)] <= mem_wdata[8 * (n - 1 - i) +: 8];
    end
  end
endmodule

/* File: verif/msm_exec_checker.sv */
// concurrent checks on the exec unit's bus and memory ports
`timescale 1ns/10ps
module msm_exec_checker
  import msm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [1:0] mem_size,
  input wire logic [2:0] mem_fc,
  input wire logic mem_ack,
  input wire logic illegal_evt,
  input wire logic priv_evt
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // zero wait states; errors only inside an access phase
  AST_PREADY: assert property (pready)
    else $error("pready low");
  AST_SLVERR: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access phase");
  // a request holds until taken, fc included
  AST_REQ_HOLD: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
    && $stable(mem_fc) && $stable(mem_size) && $stable(mem_we))
    else $error("memory request changed before ack");
  // byte transfers in a row step by two, same direction
  AST_PMOVE_STEP: assert property (mem_ack && mem_size == SZ_BYTE ##1 mem_req
    |-> mem_addr == $past(mem_addr) + 32'd2 && mem_we == $past(mem_we))
    else $error("byte transfer step wrong");
  // traps are single pulses and touch no memory
  AST_ILL_PULSE: assert property (illegal_evt |=> !illegal_evt)
    else $error("illegal pulse too long");
  AST_ILL_QUIET: assert property (illegal_evt |-> !mem_req [*2])
    else $error("memory access on illegal instruction");
  AST_PRIV: assert property (priv_evt |-> !mem_req ##1 (!priv_evt && !mem_req))
    else $error("privilege trap not clean");
  AST_EVT_EXCL: assert property (!(illegal_evt && priv_evt))
    else $error("two traps at once");
endmodule

bind msm_exec msm_exec_checker u_chk (.*);

/* File: verif/msm_exec_tb.sv */
// self-checking bench for the exec unit with a byte memory on its bus
`timescale 1ns/10ps
module msm_exec_tb;
  import msm_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [31:0] paddr, pwdata, prdata, mem_addr, mem_wdata, mem_rdata, q, st;
  logic mem_req, mem_we, mem_ack, illegal_evt, priv_evt;
  logic [1:0] mem_size;
  logic [2:0] mem_fc, seen_fc;
  logic [3:0] dly;
  logic [7:0] imq [3] = '{8'h80, 8'h00, 8'h7F};
  logic [15:0] bad [5];
  int n_mismatch = 0, cmp_count = 0, n_ill = 0, n_priv = 0;
  msm_exec u_dut (.*);
  msm_mem_model u_mem (.*);
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // trap pulse counters
  always @(posedge pclk)
  begin
    n_ill <= n_ill + int'(illegal_evt === 1'b1);
    n_priv <= n_priv + int'(priv_evt === 1'b1);
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one apb transfer; data taken at the edge that sees pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {24'h00_0000, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg_%h", a), e, q);
  endtask
  function automatic logic [7:0] dr(input int n);
    return OFS_DREG + 8'(4 * n);
  endfunction
  // start one instruction, poll busy, keep status, clear sticky flags
  task automatic run(input logic [15:0] op, input logic [15:0] ex, input logic sup);
    apb(1'b1, OFS_OPWORD, {16'h0000, op});
    apb(1'b1, OFS_EXTWORD, {16'h0000, ex});
    apb(1'b1, OFS_CTRL, {30'h0, sup, 1'b1});
    do
      apb(1'b0, OFS_STATUS, 32'h0);
    while (q[ST_BUSY] !== 1'b0);
    st = q;
    apb(1'b1, OFS_STATUS, 32'h0000_000E);
  endtask
  task automatic conclude();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // watchdog, far beyond the expected run length
  initial
  begin
    #200000;
    n_mismatch++;
    conclude();
  end
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    dly = 4'h0;
    for (int i = 0; i < 256; i++)
      u_mem.mem[i] = 8'(i);
    bad = '{{PAT_ALTSPACE, SZ_LONG, EA_DREG, 3'd1}, {PAT_ALTSPACE, SZ_WORD, EA_AREG, 3'd1},
      {PAT_ALTSPACE, SZ_BYTE, EA_EXT, 3'b010}, {PAT_ALTSPACE, SZ_LONG, EA_EXT, EXT_IMM},
      {LINE_MULW, 3'd0, OPM_MULW, EA_AREG, 3'd1}};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_CCR, 32'h0);
    rd(OFS_END, 32'h0);
    chk("pslverr", 32'h1, {31'h0, err});
    // quick move over sign boundaries, X preset to one
    foreach (imq[k])
    begin
      apb(1'b1, OFS_CCR, 32'h0000_001F);
      run({LINE_QUICK, 3'(k), 1'b0, imq[k]}, 16'h0000, 1'b0);
      rd(dr(k), {{24{imq[k][7]}}, imq[k]});
      rd(OFS_CCR, {27'h0, 1'b1, imq[k][7], imq[k] == 8'h00, 2'b00});
    end
    // word multiply ignores upper halves
    apb(1'b1, dr(1), 32'hFFFF_8000);
    apb(1'b1, dr(2), 32'h1234_0003);
    run({LINE_MULW, 3'd2, OPM_MULW, EA_DREG, 3'd1}, 16'h0000, 1'b0);
    rd(dr(2), 32'hFFFE_8000);
    rd(OFS_CCR, 32'h0000_0018);
    // long multiply, 32-bit result overflowing, then 64-bit split
    apb(1'b1, OFS_CCR, 32'h0);
    apb(1'b1, dr(3), 32'h0001_0000);
    apb(1'b1, OFS_IMM, 32'h0001_0000);
    run({PAT_MULL, EA_EXT, EXT_IMM}, {1'b0, 3'd3, 1'b1, 1'b0, 10'h000}, 1'b0);
    rd(dr(3), 32'h0);
    rd(OFS_CCR, 32'h0000_0006);
    apb(1'b1, dr(3), 32'hFFFF_FFFF);
    apb(1'b1, OFS_IMM, 32'h0000_0002);
    run({PAT_MULL, EA_EXT, EXT_IMM}, {1'b0, 3'd3, 1'b1, 1'b1, 7'h00, 3'd4}, 1'b0);
    rd(dr(4), 32'hFFFF_FFFF);
    rd(dr(3), 32'hFFFF_FFFE);
    rd(OFS_CCR, 32'h0000_0008);
    // peripheral moves, all four opmodes, slow memory
    dly <= 4'h3;
    apb(1'b1, OFS_AREG + 8'd4, 32'h0000_0020);
    apb(1'b1, dr(5), 32'hA1B2_C3D4);
    apb(1'b1, dr(7), 32'h1111_1111);
    run({LINE_ZERO, 3'd5, 3'b111, MODE_PMOVE, 3'd1}, 16'hFFFE, 1'b0);
    for (int i = 0; i < 4; i++)
      chk("pmove_byte", 8'(32'hA1B2_C3D4 >> (24 - 8 * i)), u_mem.mem[30 + 2 * i]);
    chk("pmove_gap", 32'h0000_001F, u_mem.mem[31]);
    run({LINE_ZERO, 3'd6, 3'b101, MODE_PMOVE, 3'd1}, 16'hFFFE, 1'b0);
    rd(dr(6), 32'hA1B2_C3D4);
    run({LINE_ZERO, 3'd7, 3'b100, MODE_PMOVE, 3'd1}, 16'hFFFE, 1'b0);
    rd(dr(7), 32'h1111_A1B2);
    run({LINE_ZERO, 3'd7, 3'b110, MODE_PMOVE, 3'd1}, 16'h0010, 1'b0);
    chk("pmove_word", 32'h0000_A1B2, {u_mem.mem[48], u_mem.mem[50]});
    // alternate space: user trap, then store of its own base, then loads
    dly <= 4'h0;
    apb(1'b1, OFS_FCODE, 32'h0000_0062);
    apb(1'b1, OFS_AREG + 8'd8, 32'h0000_0040);
    run({PAT_ALTSPACE, SZ_LONG, EA_POSTINC, 3'd2}, {1'b1, 3'd2, 1'b1, 11'h000}, 1'b0);
    chk("priv", 32'h1, {31'h0, st[ST_PRIV]});
    chk("priv_evt", 32'h1, 32'(n_priv));
    chk("priv_mem", 32'h0000_0040, u_mem.mem[64]);
    run({PAT_ALTSPACE, SZ_LONG, EA_POSTINC, 3'd2}, {1'b1, 3'd2, 1'b1, 11'h000}, 1'b1);
    chk("moves_st", 32'h44, {u_mem.mem[64], u_mem.mem[65], u_mem.mem[66], u_mem.mem[67]});
    chk("fc_dst", 32'h6, {29'h0, seen_fc});
    rd(OFS_AREG + 8'd8, 32'h0000_0044);
    apb(1'b1, dr(0), 32'hFFFF_FFFF);
    apb(1'b1, OFS_AREG + 8'd12, 32'h0000_005A);
    run({PAT_ALTSPACE, SZ_BYTE, EA_IND, 3'd3}, 16'h0000, 1'b1);
    rd(dr(0), 32'hFFFF_FF5A);
    chk("fc_src", 32'h2, {29'h0, seen_fc});
    apb(1'b1, OFS_AREG + 8'd12, 32'h0000_0080);
    run({PAT_ALTSPACE, SZ_WORD, EA_IND, 3'd3}, {1'b1, 3'd4, 1'b0, 11'h000}, 1'b1);
    rd(OFS_AREG + 8'd16, 32'hFFFF_8081);
    // refused address modes change nothing
    foreach (bad[k])
    begin
      run(bad[k], 16'h0000, 1'b1);
      chk("illegal", 32'h1, {31'h0, st[ST_ILLEGAL]});
      chk("illegal_evt", 32'(k + 1), 32'(n_ill));
      rd(dr(0), 32'hFFFF_FF5A);
    end
    conclude();
  end
endmodule
